// file: spims_pkg.sv
`default_nettype none
package spims_pkg;
    // ----------
    // Register map
    // ----------
    localparam logic [11:0] ADDR_DATA = 12'h000;
    localparam logic [11:0] ADDR_MODE = 12'h004;
    localparam logic [11:0] ADDR_FMT = 12'h008;
    // ----------
    // Field positions
    // ----------
    localparam int MODE_LSB = 5;
    localparam int MODE_ENABLE = 1;
    localparam int MODE_INCOMPLETE = 0;
    localparam int FMT_CPOL = 5;
    localparam int FMT_EDGE = 4;
    localparam int FMT_MSB = 3;
    localparam int FMT_SELECT_PIN_ENABLE_BIT = 2;
    localparam int FMT_WRITE_COLLISION_FLAG = 1;
    localparam int FMT_DONE = 0;
    // ----------
    // Reset values and masks
    // ----------
    localparam logic [7:0] MODE_RESET = 8'hE0;
    localparam logic [7:0] MODE_WMASK = 8'hEF;
    localparam logic [7:0] FMT_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // ----------
    // Operating modes
    // ----------
    localparam logic [2:0] OPM_DIV4 = 3'h0;
    localparam logic [2:0] OPM_DIV16 = 3'h1;
    localparam logic [2:0] OPM_DIV64 = 3'h2;
    localparam logic [2:0] OPM_SUB = 3'h3;
    localparam logic [2:0] OPM_TIMER = 3'h4;
    localparam logic [2:0] OPM_SLAVE = 3'h5;
    localparam logic [2:0] OPM_I2C = 3'h6;
    localparam logic [2:0] OPM_OFF = 3'h7;
    // Half-period counts of the serial clock in system clocks, less one.
    localparam logic [4:0] HALF_DIV4 = 5'h01;
    localparam logic [4:0] HALF_DIV16 = 5'h07;
    localparam logic [4:0] HALF_DIV64 = 5'h1F;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // ----------
    // Carrier types
    // ----------
    typedef struct packed {
        logic sck;
        logic sckOe;
        logic sdo;
        logic sdoOe;
    } spims_pins_t;
endpackage : spims_pkg
`default_nettype wire

// file: spims_tick_gen.sv
`default_nettype none
// Produces one-cycle ticks at each half period of the master serial clock.
module spims_tick_gen (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic run,
    input wire logic [2:0] opMode,
    input wire logic subTick,
    input wire logic timerTick,
    output logic halfTick
);
    logic [4:0] divCount;
    logic [4:0] limit;
    logic timerHalf;

    always_comb begin
        unique case (opMode)
            spims_pkg::OPM_DIV4: limit = spims_pkg::HALF_DIV4;
            spims_pkg::OPM_DIV16: limit = spims_pkg::HALF_DIV16;
            default: limit = spims_pkg::HALF_DIV64;
        endcase
    end

    // Timer source: the serial clock toggles on every match event, which makes
    // its rate half the match rate.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            divCount <= 5'h00;
            timerHalf <= 1'b0;
        end else if (!run) begin
            divCount <= 5'h00;
            timerHalf <= 1'b0;
        end else begin
            timerHalf <= timerTick;
            if (divCount == limit) begin
                divCount <= 5'h00;
            end else begin
                divCount <= divCount + 5'h01;
            end
        end
    end

    always_comb begin
        unique case (opMode)
            spims_pkg::OPM_SUB: halfTick = run && subTick;
            spims_pkg::OPM_TIMER: halfTick = run && timerHalf;
            default: halfTick = run && (divCount == limit);
        endcase
    end
endmodule : spims_tick_gen
`default_nettype wire

// file: spims_core.sv
`default_nettype none
// What this block does
// [R01] Mode codes 0-4 pick master clock: /4, /16, /64, sub clock, half timer rate.
// [R02] Code 5 is slave, 6 selects the other function, 7 turns it off.
// [R03] Enable low releases all pins and stops activity; high makes it active.
// [R04] Raising enable keeps control register contents untouched.
// [R05] Slave deselected mid-byte sets incomplete and done flags.
// [R06] Software setting the incomplete flag leaves the done flag alone.
// [R07] Idle clock is high with polarity 0 and low with polarity 1.
// [R08] Capture edge follows polarity XOR edge-select as the table gives.
// [R09] Software fixes polarity and edge before starting a transfer.
// [R10] Shift-order bit 1 sends and receives MSB first, 0 LSB first.
// [R11] Select-pin enable 0 ignores the select pin; 1 uses it.
// [R12] Data writes during a transfer are dropped and set the collision flag.
// [R13] Collision flag clears only by software writing 0.
// [R14] Done flag is set at every byte end and held until software clears it.
// [R15] Master data write starts the clock at once; send and receive together.
// [R16] Slave shifts out and in on the edges from the external master.
// [R17] External master asserts select before giving any clock.
// [R18] Logic runs whenever its clock source runs; no idle gating.
// [R19] Slave with select-pin enable 0 is always selected.
// [R20] Eight-bit data register, read and write, holds both directions.
// [R21] Top two format bits store and return whatever software writes.
// [R22] When enabled, data-out idles high; master drives idle clock, slave floats it.
// [R23] Received bits gather in a shift buffer, copied to data at the eighth capture edge.
// [R24] Exactly eight clock periods per byte; done after the eighth bit.
module spims_core (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic subTick,
    input wire logic timerTick,
    input wire logic sckIn,
    input wire logic sdiIn,
    input wire logic selectIn_n,
    output spims_pkg::spims_pins_t pins,
    output logic doneFlag
);
    // ----------
    // Registers
    // ----------
    logic [7:0] modeReg;
    logic [7:0] fmtReg;

    logic [7:0] dataReg;
    logic [7:0] shiftBuf;
    logic [3:0] bitCount;
    logic busy;

    logic sckLevel;
    logic sckPrev;
    logic selPrev_n;

    logic halfTick;

    typedef enum logic [1:0] {SPIMS_IDLE, SPIMS_LEAD, SPIMS_TRAIL} spims_state_t;
    spims_state_t state;

    wire logic [2:0] opMode = modeReg[spims_pkg::MODE_LSB +: 3];
    wire logic enabled = modeReg[spims_pkg::MODE_ENABLE]; // R03

    wire logic isMaster = enabled && (opMode <= spims_pkg::OPM_TIMER); // R01
    wire logic isSlave = enabled && (opMode == spims_pkg::OPM_SLAVE); // R02

    wire logic cpol = fmtReg[spims_pkg::FMT_CPOL];
    wire logic edgeSel = fmtReg[spims_pkg::FMT_EDGE];
    wire logic msbFirst = fmtReg[spims_pkg::FMT_MSB];
    wire logic select_pin_enable_bit = fmtReg[spims_pkg::FMT_SELECT_PIN_ENABLE_BIT];

    wire logic idleLevel = ~cpol; // R07
    // Edge-select 1 captures on the edge leaving the idle level, 0 on the return.
    wire logic captureOnLead = edgeSel; // R08

    // ----------
    // Bus decode
    // ----------
    wire logic access = psel && penable;
    wire logic wrData = access && pwrite && (paddr == spims_pkg::ADDR_DATA);
    wire logic wrMode = access && pwrite && (paddr == spims_pkg::ADDR_MODE);
    wire logic wrFmt = access && pwrite && (paddr == spims_pkg::ADDR_FMT);

    wire logic mapped = (paddr == spims_pkg::ADDR_DATA) || (paddr == spims_pkg::ADDR_MODE)
        || (paddr == spims_pkg::ADDR_FMT);

    // ----------
    // Slave link events
    // ----------
    wire logic selected = !select_pin_enable_bit || !selectIn_n; // R11 R19

    wire logic sckRise = sckIn && !sckPrev;
    wire logic sckFall = !sckIn && sckPrev;
    wire logic sckLead = cpol ? sckRise : sckFall;
    wire logic sckTrail = cpol ? sckFall : sckRise;

    // Edges while no byte is loaded are ignored, so a stray clock cannot shift.
    wire logic slvCapture = isSlave && selected && busy
        && (captureOnLead ? sckLead : sckTrail); // R16
    wire logic slvLaunch = isSlave && selected && busy
        && (captureOnLead ? sckTrail : sckLead);
    wire logic deselect = isSlave && select_pin_enable_bit && selectIn_n && !selPrev_n;
    wire logic abortSlave = deselect && busy && (bitCount != 4'h0); // R05

    // Master edges come from the half-period tick in the LEAD and TRAIL states.
    wire logic mstLeadEdge = isMaster && halfTick && (state == SPIMS_LEAD);
    wire logic mstTrailEdge = isMaster && halfTick && (state == SPIMS_TRAIL);
    wire logic mstCapture = captureOnLead ? mstLeadEdge : mstTrailEdge;
    wire logic mstLaunch = captureOnLead ? mstTrailEdge : mstLeadEdge;

    wire logic capture = mstCapture || slvCapture;
    wire logic launch = mstLaunch || slvLaunch;
    wire logic lastBit = capture && (bitCount == spims_pkg::BITS_PER_BYTE - 4'h1); // R24

    // A master capturing on the leading edge still owes the last trailing edge, so
    // its byte ends there and every byte keeps eight whole clock periods.
    wire logic trailOwed = isMaster && captureOnLead;
    wire logic byteEnd = trailOwed ? (mstTrailEdge && bitCount == spims_pkg::BITS_PER_BYTE)
        : lastBit; // R24

    wire logic startWrite = wrData && !busy;
    wire logic collide = wrData && busy; // R12
    wire logic [7:0] rxByte = msbFirst ? {shiftBuf[6:0], sdiIn} : {sdiIn, shiftBuf[7:1]};

    spims_tick_gen u_tick (
        .clk(clk),
        .arst_n(arst_n),
        .run(busy && isMaster),
        .opMode(opMode),
        .subTick(subTick),
        .timerTick(timerTick),
        .halfTick(halfTick)
    );

    // ----------
    // Control registers
    // ----------
    // Enable changes touch nothing else in the control registers.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            modeReg <= spims_pkg::MODE_RESET;
        end else begin
            if (wrMode) begin
                modeReg[7:1] <= pwdata[7:1] & spims_pkg::MODE_WMASK[7:1]; // R04
            end
            if (abortSlave) begin
                modeReg[spims_pkg::MODE_INCOMPLETE] <= 1'b1; // R05
            end else if (wrMode) begin
                modeReg[spims_pkg::MODE_INCOMPLETE] <= pwdata[spims_pkg::MODE_INCOMPLETE];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fmtReg <= spims_pkg::FMT_RESET;
        end else begin
            if (wrFmt) begin
                fmtReg[7:2] <= pwdata[7:2]; // R21
            end
            if (collide) begin
                fmtReg[spims_pkg::FMT_WRITE_COLLISION_FLAG] <= 1'b1; // R12
            end else if (wrFmt) begin
                fmtReg[spims_pkg::FMT_WRITE_COLLISION_FLAG] <= pwdata[spims_pkg::FMT_WRITE_COLLISION_FLAG]; // R13
            end
            // A software write to the incomplete flag never reaches this bit.
            if (byteEnd || abortSlave) begin
                fmtReg[spims_pkg::FMT_DONE] <= 1'b1; // R14 R06
            end else if (wrFmt) begin
                fmtReg[spims_pkg::FMT_DONE] <= pwdata[spims_pkg::FMT_DONE];
            end
        end
    end

    // ----------
    // Transfer engine
    // ----------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dataReg <= spims_pkg::DATA_RESET;
        end else if (lastBit) begin
            dataReg <= rxByte; // R23
        end else if (startWrite) begin
            dataReg <= pwdata[7:0]; // R20
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            bitCount <= 4'h0;
            shiftBuf <= 8'h00;
            state <= SPIMS_IDLE;
        end else if (!enabled || abortSlave || byteEnd) begin
            busy <= 1'b0;
            bitCount <= 4'h0;
            state <= SPIMS_IDLE;
        end else if (startWrite && (isMaster || isSlave)) begin
            busy <= 1'b1; // R15
            bitCount <= 4'h0;
            shiftBuf <= pwdata[7:0];
            state <= isMaster ? SPIMS_LEAD : SPIMS_IDLE;
        end else begin
            if (capture) begin
                bitCount <= bitCount + 4'h1;
                shiftBuf <= rxByte; // R10
            end
            if (mstLeadEdge) begin
                state <= SPIMS_TRAIL;
            end else if (mstTrailEdge) begin
                state <= SPIMS_LEAD;
            end
        end
    end

    // The data-out bit is the head of the buffer in the chosen order.
    wire logic headBit = msbFirst ? shiftBuf[7] : shiftBuf[0];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sckLevel <= 1'b1;
            sckPrev <= 1'b0;
            selPrev_n <= 1'b1;
            pins <= '0;
        end else begin
            sckPrev <= sckIn;
            selPrev_n <= selectIn_n;
            if (mstLeadEdge) begin
                sckLevel <= ~idleLevel;
            end else if (mstTrailEdge || !busy) begin
                sckLevel <= idleLevel; // R07
            end
            pins.sck <= (mstLeadEdge || mstTrailEdge) ? (mstLeadEdge ? ~idleLevel : idleLevel)
                : (busy ? sckLevel : idleLevel);
            pins.sckOe <= isMaster; // R22
            pins.sdoOe <= isMaster || (isSlave && selected); // R03 R22
            if (!busy && !startWrite) begin
                pins.sdo <= 1'b1; // R22
            end else if (startWrite) begin
                pins.sdo <= msbFirst ? pwdata[7] : pwdata[0];
            end else if (launch || capture) begin
                pins.sdo <= launch ? headBit : pins.sdo;
            end
        end
    end

    assign doneFlag = fmtReg[spims_pkg::FMT_DONE];

    // ----------
    // Bus answer
    // ----------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            unique case (paddr)
                spims_pkg::ADDR_DATA: prdata <= {24'h00_0000, dataReg};
                spims_pkg::ADDR_MODE: prdata <= {24'h00_0000, modeReg};
                spims_pkg::ADDR_FMT: prdata <= {24'h00_0000, fmtReg};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------
    // Checks
    // ----------
    property p_collide;
        @(posedge clk) disable iff (!arst_n)
        collide && !lastBit |=> fmtReg[spims_pkg::FMT_WRITE_COLLISION_FLAG] && $stable(dataReg);
    endproperty
    a_collide: assert property (p_collide) else $error("collision not flagged"); // R12

    property p_wcolHold;
        @(posedge clk) disable iff (!arst_n)
        fmtReg[spims_pkg::FMT_WRITE_COLLISION_FLAG] && !wrFmt |=> fmtReg[spims_pkg::FMT_WRITE_COLLISION_FLAG];
    endproperty
    a_wcolHold: assert property (p_wcolHold) else $error("collision flag self-cleared"); // R13

    property p_done;
        @(posedge clk) disable iff (!arst_n)
        byteEnd |=> fmtReg[spims_pkg::FMT_DONE] && !busy;
    endproperty
    a_done: assert property (p_done) else $error("done flag missing"); // R14

    property p_abort;
        @(posedge clk) disable iff (!arst_n)
        abortSlave |=> modeReg[spims_pkg::MODE_INCOMPLETE] && fmtReg[spims_pkg::FMT_DONE];
    endproperty
    a_abort: assert property (p_abort) else $error("incomplete flags wrong"); // R05

    property p_start;
        @(posedge clk) disable iff (!arst_n)
        startWrite && isMaster |=> busy && state == SPIMS_LEAD;
    endproperty
    a_start: assert property (p_start) else $error("master did not start"); // R15

    property p_idleSck;
        @(posedge clk) disable iff (!arst_n)
        !busy && isMaster ##1 !busy && $stable(cpol) |-> pins.sck == ~cpol;
    endproperty
    a_idleSck: assert property (p_idleSck) else $error("idle clock level wrong"); // R07

    property p_eight;
        @(posedge clk) disable iff (!arst_n)
        busy |-> bitCount <= spims_pkg::BITS_PER_BYTE;
    endproperty
    a_eight: assert property (p_eight) else $error("bit count overrun"); // R24

    property p_off;
        @(posedge clk) disable iff (!arst_n)
        !enabled ##1 !enabled |-> !pins.sckOe && !pins.sdoOe && !busy;
    endproperty
    a_off: assert property (p_off) else $error("pins driven while disabled"); // R03

    property p_sdoIdle;
        @(posedge clk) disable iff (!arst_n)
        (isMaster || isSlave) && !busy ##1 !busy |-> pins.sdo;
    endproperty
    a_sdoIdle: assert property (p_sdoIdle) else $error("data-out not idle high"); // R22


    c_master: cover property (@(posedge clk) disable iff (!arst_n) byteEnd && isMaster);
    c_slave: cover property (@(posedge clk) disable iff (!arst_n) byteEnd && isSlave);
    c_abort: cover property (@(posedge clk) disable iff (!arst_n) abortSlave);
    c_coll: cover property (@(posedge clk) disable iff (!arst_n) collide);
endmodule : spims_core
`default_nettype wire

// file: spims_peer_model.sv
`default_nettype none
// ----------
// Far-side device: a slave when the block is master, else a master
// ----------
module spims_peer_model #(
    parameter int HALF = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic actMaster,
    input wire logic cpol,
    input wire logic edgeSel,
    input wire logic msbFirst,
    input wire logic useSelect,
    input wire logic startReq,
    input wire logic [3:0] nBits,
    input wire logic [7:0] txByte,
    input wire logic sckLine,
    input wire logic sdoLine,
    output logic sckOut,
    output logic selectOut_n,
    output logic sdiOut,
    output logic [7:0] rxByte,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sckPrev;
    logic [7:0] txSh;
    logic [3:0] nCap;
    int cnt;
    int halves;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sckPrev <= 1'b1;
            sckOut <= 1'b1;
            selectOut_n <= 1'b1;
            sdiOut <= 1'b0;
            txSh <= 8'h00;
            rxByte <= 8'h00;
            nCap <= 4'h0;
            cnt <= 0;
            halves <= 0;
            busy <= 1'b0;
        end else if (startReq) begin
            txSh <= txByte;
            sdiOut <= msbFirst ? txByte[7] : txByte[0];
            selectOut_n <= ~useSelect;
            nCap <= 4'h0;
            cnt <= 0;
            halves <= 0;
            busy <= 1'b1;
        end else begin
            sckPrev <= sckLine;
            if (!busy) begin
                sckOut <= ~cpol;
            end
            // Data moves on the edge opposite to capture, so it is steady a half period.
            if (busy && sckLine != sckPrev && sckLine == (cpol == edgeSel)) begin
                rxByte <= msbFirst ? {rxByte[6:0], sdoLine} : {sdoLine, rxByte[7:1]};
                nCap <= nCap + 4'h1;
            end else if (busy && sckLine != sckPrev && nCap != 4'h0 && nCap < nBits) begin
                txSh <= msbFirst ? txSh << 1 : txSh >> 1;
                sdiOut <= msbFirst ? txSh[6] : txSh[1];
            end
            if (actMaster && busy) begin
                cnt <= (cnt == HALF) ? 0 : cnt + 1;
                if (cnt == HALF && halves < 2 * nBits) begin
                    sckOut <= ~sckOut;
                    halves <= halves + 1;
                end
            end
            if (busy && (actMaster ? (cnt == HALF && halves == 2 * nBits) : nCap == 4'h8)) begin
                busy <= 1'b0;
                selectOut_n <= 1'b1;
                // A released data line must not keep showing the last bit.
                sdiOut <= ~sdiOut;
            end
        end
    end
endmodule : spims_peer_model
`default_nettype wire

// file: spi_master_slave_port_test.sv
`default_nettype none
module spi_master_slave_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr, subTick, timerTick, doneFlag, rdErr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    spims_pkg::spims_pins_t pins;
    logic pAct, pCpol, pEdge, pMsb, pSel, pStart, pBusy, pSck, pSelN, pSdi, sckPrevTb;
    logic [3:0] pBits;
    logic [7:0] pTx, pRx;
    logic [1:0] tickSel;
    int tickCnt, nToggles, firstT, lastT, cyc, numErrors, nChecks;
    wire logic sckLine = pins.sckOe ? pins.sck : pSck;
    spims_core i_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .subTick(subTick), .timerTick(timerTick), .sckIn(sckLine),
        .sdiIn(pSdi), .selectIn_n(pSelN), .pins(pins), .doneFlag(doneFlag));
    spims_peer_model #(.HALF(8)) i_peer (.clk(clk), .arst_n(arst_n), .actMaster(pAct),
        .cpol(pCpol), .edgeSel(pEdge), .msbFirst(pMsb), .useSelect(pSel), .startReq(pStart),
        .nBits(pBits), .txByte(pTx), .sckLine(sckLine), .sdoLine(pins.sdo), .sckOut(pSck),
        .selectOut_n(pSelN), .sdiOut(pSdi), .rxByte(pRx), .busy(pBusy));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ----------
    // Tick sources and serial clock edge monitor
    // ----------
    always @(posedge clk) begin
        tickCnt <= (tickCnt == 5) ? 0 : tickCnt + 1;
        subTick <= tickSel[0] && tickCnt == 5;
        timerTick <= tickSel[1] && tickCnt == 5;
        cyc <= cyc + 1;
        sckPrevTb <= pins.sck;
        if (pins.sckOe === 1'b1 && pins.sck !== sckPrevTb) begin
            if (nToggles == 0) firstT <= cyc;
            lastT <= cyc;
            nToggles <= nToggles + 1;
        end
    end
    // ----------
    // Shared tasks
    // ----------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("Error %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic chkBit(input string what, input logic exp, input logic got);
        check(what, 32'(exp), 32'(got));
    endtask : chkBit
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic expectReg(input string what, input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        check(what, 32'(exp), rdData);
    endtask : expectReg
    task automatic waitDone(input int limit);
        for (int i = 0; i < limit && doneFlag !== 1'b1; i++) @(posedge clk);
        chkBit("done flag", 1'b1, doneFlag);
    endtask : waitDone
    // ----------
    // Scenarios
    // ----------
    task automatic testReset;
        expectReg("mode reset", spims_pkg::ADDR_MODE, spims_pkg::MODE_RESET);
        expectReg("format reset", spims_pkg::ADDR_FMT, spims_pkg::FMT_RESET);
        chkBit("pins off", 1'b0, pins.sckOe | pins.sdoOe);
        apb(1'b0, 12'h00C, 8'h00);
        chkBit("unmapped error", 1'b1, rdErr);
        check("unmapped data", 32'h0000_0000, rdData);
        wr(spims_pkg::ADDR_MODE, 8'hF0);
        expectReg("mode mask", spims_pkg::ADDR_MODE, 8'hE0);
        wr(spims_pkg::ADDR_DATA, 8'h5A);
        expectReg("data rw", spims_pkg::ADDR_DATA, 8'h5A);
        wr(spims_pkg::ADDR_FMT, 8'hD4);
        wr(spims_pkg::ADDR_MODE, {spims_pkg::OPM_DIV4, 5'b00000});
        chkBit("disabled pins", 1'b0, pins.sckOe | pins.sdoOe);
        wr(spims_pkg::ADDR_MODE, {spims_pkg::OPM_DIV4, 5'b00010});
        expectReg("format kept", spims_pkg::ADDR_FMT, 8'hD4);
        for (int m = 6; m < 8; m++) begin
            wr(spims_pkg::ADDR_MODE, {m[2:0], 5'b00010});
            wr(spims_pkg::ADDR_DATA, 8'h33);
            repeat (100) @(posedge clk);
            chkBit("inactive mode", 1'b0, doneFlag | pins.sckOe);
        end
        $display("reset and register test done");
    endtask : testReset
    task automatic masterXfer(input logic [2:0] opm, input logic [1:0] ts, input int half,
        input logic [2:0] fmt, input logic collide, input logic [7:0] tx, input logic [7:0] rxv);
        logic [7:0] base;
        base = {2'b11, fmt, 3'b100};
        tickSel <= ts;
        wr(spims_pkg::ADDR_FMT, base);
        wr(spims_pkg::ADDR_MODE, {opm, 5'b00010});
        @(posedge clk);
        chkBit("idle sck", ~fmt[2], pins.sck);
        chkBit("idle sdo", 1'b1, pins.sdo & pins.sdoOe & pins.sckOe);
        {pCpol, pEdge, pMsb, pAct, pBits, pTx} <= {fmt, 1'b0, 4'h8, rxv};
        pStart <= 1'b1;
        nToggles <= 0;
        @(posedge clk);
        pStart <= 1'b0;
        wr(spims_pkg::ADDR_DATA, tx);
        if (collide) wr(spims_pkg::ADDR_DATA, 8'hFF);
        waitDone(2000);
        repeat (4) @(posedge clk);
        check("clock edges", 32'h0000_0010, nToggles);
        check("bit span", 15 * half, lastT - firstT);
        check("peer rx", 32'(tx), 32'(pRx));
        expectReg("rx data", spims_pkg::ADDR_DATA, rxv);
        expectReg("flags", spims_pkg::ADDR_FMT, base | {6'h00, collide, 1'b1});
        wr(spims_pkg::ADDR_FMT, base);
        chkBit("done clear", 1'b0, doneFlag);
        $display("master test mode %0d done", opm);
    endtask : masterXfer
    task automatic slaveXfer(input logic [2:0] fmt, input logic select_pin_enable_bit, input logic [3:0] nb,
        input logic [7:0] tx, input logic [7:0] rxv);
        logic [7:0] base;
        base = {2'b00, fmt, select_pin_enable_bit, 2'b00};
        tickSel <= 2'b00;
        wr(spims_pkg::ADDR_FMT, base);
        wr(spims_pkg::ADDR_MODE, {spims_pkg::OPM_SLAVE, 5'b00010});
        @(posedge clk);
        chkBit("slave sck released", 1'b0, pins.sckOe);
        wr(spims_pkg::ADDR_DATA, tx);
        {pCpol, pEdge, pMsb} <= fmt;
        {pAct, pSel, pBits, pTx} <= {1'b1, select_pin_enable_bit, nb, rxv};
        pStart <= 1'b1;
        @(posedge clk);
        pStart <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 1000 && pBusy === 1'b1; i++) @(posedge clk);
        waitDone(50);
        if (nb == 4'h8) begin
            check("peer rx", 32'(tx), 32'(pRx));
            expectReg("rx data", spims_pkg::ADDR_DATA, rxv);
            expectReg("no abort", spims_pkg::ADDR_MODE, {spims_pkg::OPM_SLAVE, 5'b00010});
        end else begin
            expectReg("abort", spims_pkg::ADDR_MODE, {spims_pkg::OPM_SLAVE, 5'b00011});
        end
        wr(spims_pkg::ADDR_MODE, {spims_pkg::OPM_SLAVE, 5'b00010});
        wr(spims_pkg::ADDR_FMT, base);
        $display("slave test done");
    endtask : slaveXfer
    task automatic testSoftIncomplete;
        wr(spims_pkg::ADDR_MODE, {spims_pkg::OPM_SLAVE, 5'b00011});
        repeat (3) @(posedge clk);
        chkBit("done untouched", 1'b0, doneFlag);
        expectReg("incomplete set", spims_pkg::ADDR_MODE, {spims_pkg::OPM_SLAVE, 5'b00011});
        expectReg("done bit clear", spims_pkg::ADDR_FMT, 8'h04);
        $display("software incomplete test done");
    endtask : testSoftIncomplete
    task automatic reportAndStop;
        $display("checks %0d, errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : reportAndStop
    initial begin
        {arst_n, psel, penable, pwrite, paddr, pwdata, subTick, timerTick} = '0;
        {pAct, pCpol, pEdge, pMsb, pSel, pStart, pBits, pTx, tickSel, sckPrevTb} = '0;
        {tickCnt, nToggles, firstT, lastT, cyc, numErrors, nChecks} = '0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        testReset();
        masterXfer(spims_pkg::OPM_DIV4, 2'b00, 2, 3'b000, 1'b0, 8'h1D, 8'h6B);
        masterXfer(spims_pkg::OPM_DIV16, 2'b00, 8, 3'b011, 1'b1, 8'h2C, 8'h71);
        masterXfer(spims_pkg::OPM_DIV64, 2'b00, 32, 3'b101, 1'b0, 8'h93, 8'h4E);
        masterXfer(spims_pkg::OPM_DIV4, 2'b00, 2, 3'b110, 1'b0, 8'hE8, 8'h35);
        masterXfer(spims_pkg::OPM_SUB, 2'b01, 6, 3'b001, 1'b0, 8'h4B, 8'hD2);
        masterXfer(spims_pkg::OPM_TIMER, 2'b10, 6, 3'b010, 1'b0, 8'h07, 8'hA1);
        slaveXfer(3'b001, 1'b1, 4'h8, 8'h59, 8'hC6);
        slaveXfer(3'b110, 1'b0, 4'h8, 8'h8E, 8'h17);
        slaveXfer(3'b000, 1'b1, 4'h3, 8'h62, 8'hB4);
        testSoftIncomplete();
        reportAndStop();
    end
    initial begin
        repeat (40000) @(posedge clk);
        numErrors++;
        $display("Error watchdog: expected end of tests, seen none");
        reportAndStop();
    end
endmodule : spi_master_slave_port_test
`default_nettype wire
